// ### core/daqic_ctl.sv
// Local design decision: the strobed register port.
`timescale 1ns/100ps

//Function
//[RULE_01] Source bit picks counter 1 clock
//[RULE_02] Counter 1 frequency: 10 MHz or 100 kHz
//[RULE_03] Counter 0 frequency: 10 MHz or 1 MHz
//[RULE_04] Digital I/O requests pass only when enabled
//[RULE_05] Analog requests pass only when enabled
//[RULE_06] No analog output interrupt exists
//[RULE_07] All sources share one interrupt line
//[RULE_08] Handler reads status, clears via offset 0
//[RULE_09] Basic threshold is six bits, 1 to 48
//[RULE_10] Basic: above 48 becomes 48, 0 becomes 1
//[RULE_11] Reaching threshold raises analog pending flag
//[RULE_12] Enhanced byte is threshold bits 10 to 3
//[RULE_13] Enhanced threshold 8 to 2048, steps of 8
//[RULE_14] First enhanced entry loads threshold 1024
//[RULE_15] Offset 5 read: count or threshold
//[RULE_16] Handler reads the right number of samples
//[RULE_17] Higher rates want higher threshold, headroom
//[RULE_18] Pending flags in status bits 6 to 4
//[RULE_19] Enhanced: offset 6 gives count upper nibble
//[RULE_20] Trigger select; no software start when enabled
//[RULE_21] DMA and timer enable bits gate operation
module daqic_ctl
   import daqic_pkg::*;
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input daqic_reg_req_t reg_req_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [CNT_W-1:0] fifo_count_in,
   input wire logic enhanced_fifo_mode_in,
   input wire logic timer_event_in,
   input wire logic dio_event_in,
   input wire logic ctr0_output_in,
   input wire logic [3:0] adc_channel_in,
   input wire logic ctr1_external_clock_in,
   input wire logic external_adc_trigger_in,
   output logic host_irq_out,
   output logic dma_operation_enable_out,
   output logic ctr0_tick_out,
   output logic ctr1_tick_out,
   output logic adc_trigger_out,
   output logic adc_sw_start_out
);

   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   logic [7:0] ctl_ff;
   logic [BASIC_W-1:0] basic_thr_ff;
   logic [CNT_W-1:0] enh_thr_ff;
   logic enh_seen_ff;
   logic enh_mode_ff;
   logic timer_irq_pending_ff;
   logic dio_irq_pending_ff;
   logic analog_irq_pending_ff;
   logic reached_ff;
   logic [7:0] rdata_ff;

   wire logic wr_cmd = reg_req_in.wr && (reg_req_in.addr == OFS_CMD);
   wire logic wr_ctl = reg_req_in.wr && (reg_req_in.addr == OFS_CTL);
   wire logic wr_thr = reg_req_in.wr && (reg_req_in.addr == OFS_THR);

   wire logic ctr1_clock_source_sel = ctl_ff[CTL_CK1_SRC];
   wire logic ctr1_input_freq_sel = ctl_ff[CTL_FRQ1];
   wire logic ctr0_input_freq_sel = ctl_ff[CTL_FRQ0];
   wire logic adc_trigger_source_sel = ctl_ff[CTL_TRIG_SEL];
   wire logic dma_operation_enable = ctl_ff[CTL_DMA_EN];
   wire logic timer_irq_enable = ctl_ff[CTL_TIMER_EN];
   wire logic dio_irq_enable = ctl_ff[CTL_DIO_EN];
   wire logic analog_irq_enable = ctl_ff[CTL_ANALOG_EN];

   // ---------------------------------------------------------------
   // Pin synchronisers for the external clock and trigger.
   // ---------------------------------------------------------------
   logic [1:0] pin_meta_ff;
   logic [1:0] pin_sync_ff;
   logic [1:0] pin_last_ff;

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         pin_meta_ff <= 2'h0;
         pin_sync_ff <= 2'h0;
         pin_last_ff <= 2'h0;
      end else begin
         pin_meta_ff <= {external_adc_trigger_in, ctr1_external_clock_in};
         pin_sync_ff <= pin_meta_ff;
         pin_last_ff <= pin_sync_ff;
      end
   end

   wire logic [1:0] pin_rise = pin_sync_ff & ~pin_last_ff;

   // ---------------------------------------------------------------
   // Counter input clocks
   // ---------------------------------------------------------------
   daqic_tick_t tick;

   daqic_tick_div u_div (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .tick_out(tick)
   );

   wire logic ctr0_rate = ctr0_input_freq_sel ? tick.t1m : tick.t10m; // [RULE_03]
   wire logic ctr1_rate = ctr1_input_freq_sel ? tick.t100k : tick.t10m; // [RULE_02]
   wire logic ctr1_pick = ctr1_clock_source_sel ? pin_rise[0] : ctr1_rate; // [RULE_01]

   // ---------------------------------------------------------------
   // Threshold formats
   // ---------------------------------------------------------------
   wire logic [BASIC_W-1:0] wr_basic = reg_req_in.wdata[BASIC_W-1:0]; // [RULE_09]
   wire logic [BASIC_W-1:0] basic_clamped =
      (wr_basic == '0) ? BASIC_MIN :
      (wr_basic > BASIC_MAX) ? BASIC_MAX : wr_basic; // [RULE_10]
   wire logic [CNT_W-1:0] enh_written =
      (reg_req_in.wdata == 8'h00) ? ENH_MAX :
      {1'b0, reg_req_in.wdata, ENH_LOW_ZERO}; // [RULE_12] [RULE_13]
   wire logic enh_first = enhanced_fifo_mode_in && !enh_mode_ff && !enh_seen_ff; // [RULE_14]
   wire logic [CNT_W-1:0] cur_thr = enhanced_fifo_mode_in ? enh_thr_ff :
      {{(CNT_W-BASIC_W){1'b0}}, basic_thr_ff};
   wire logic reached = (fifo_count_in >= cur_thr); // [RULE_11]

   // ---------------------------------------------------------------
   // Interrupt sources
   // ---------------------------------------------------------------
   wire logic set_timer = timer_event_in && timer_irq_enable; // [RULE_21]
   wire logic set_dio = dio_event_in && dio_irq_enable; // [RULE_04]
   wire logic set_analog = reached && !reached_ff && analog_irq_enable; // [RULE_05] [RULE_11]
   wire logic clr_timer = wr_cmd && reg_req_in.wdata[CMD_CLR_TIMER];
   wire logic clr_dio = wr_cmd && reg_req_in.wdata[CMD_CLR_DIO];
   wire logic clr_analog = wr_cmd && reg_req_in.wdata[CMD_CLR_ANALOG];

   // A hardware set in the clearing cycle wins so no request is lost.
   wire logic nxt_timer_pending = set_timer || (timer_irq_pending_ff && !clr_timer);
   wire logic nxt_dio_pending = set_dio || (dio_irq_pending_ff && !clr_dio);
   wire logic nxt_analog_pending = set_analog || (analog_irq_pending_ff && !clr_analog);

   // Analog output events have no source here at all.
   wire logic irq_any = (timer_irq_pending_ff && timer_irq_enable) ||
      (dio_irq_pending_ff && dio_irq_enable) ||
      (analog_irq_pending_ff && analog_irq_enable); // [RULE_06] [RULE_07]

   // ---------------------------------------------------------------
   // Conversion trigger
   // ---------------------------------------------------------------
   wire logic hw_trig = adc_trigger_source_sel ? pin_rise[1] : ctr0_output_in;
   wire logic nxt_trigger = analog_irq_enable && hw_trig; // [RULE_20]
   wire logic nxt_sw_start = wr_cmd && reg_req_in.wdata[CMD_SW_START] &&
      !analog_irq_enable; // [RULE_20]

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   wire logic [7:0] rd_thr = enhanced_fifo_mode_in ? fifo_count_in[7:0] :
      {{(8-BASIC_W){1'b0}}, basic_thr_ff}; // [RULE_15]
   wire logic [7:0] rd_fdh = enhanced_fifo_mode_in ? {4'h0, fifo_count_in[11:8]} :
      fifo_count_in[7:0]; // [RULE_19]
   wire logic [7:0] rd_stat = {1'b0, timer_irq_pending_ff, dio_irq_pending_ff,
      analog_irq_pending_ff, adc_channel_in}; // [RULE_18]
   wire logic [7:0] rd_mux =
      (reg_req_in.addr == OFS_CTL) ? ctl_ff :
      (reg_req_in.addr == OFS_THR) ? rd_thr :
      (reg_req_in.addr == OFS_FDH) ? rd_fdh :
      (reg_req_in.addr == OFS_STAT) ? rd_stat : 8'h00;
   wire logic [7:0] nxt_rdata = reg_req_in.rd ? rd_mux : 8'h00;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         ctl_ff <= CTL_RESET;
         basic_thr_ff <= BASIC_RESET;
         enh_thr_ff <= ENH_RESET;
         enh_seen_ff <= 1'b0;
         enh_mode_ff <= 1'b0;
      end else begin
         enh_mode_ff <= enhanced_fifo_mode_in;
         if (enh_first) begin
            enh_seen_ff <= 1'b1;
         end
         if (wr_ctl) begin
            ctl_ff <= reg_req_in.wdata;
         end
         if (wr_thr && !enhanced_fifo_mode_in) begin
            basic_thr_ff <= basic_clamped; // [RULE_10]
         end
         if (wr_thr && enhanced_fifo_mode_in) begin
            enh_thr_ff <= enh_written; // [RULE_12]
         end else if (enh_first) begin
            enh_thr_ff <= ENH_AUTO; // [RULE_14]
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         timer_irq_pending_ff <= 1'b0;
         dio_irq_pending_ff <= 1'b0;
         analog_irq_pending_ff <= 1'b0;
         reached_ff <= 1'b0;
      end else begin
         timer_irq_pending_ff <= nxt_timer_pending;
         dio_irq_pending_ff <= nxt_dio_pending;
         analog_irq_pending_ff <= nxt_analog_pending; // [RULE_11]
         reached_ff <= reached;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         rdata_ff <= 8'h00;
         host_irq_out <= 1'b0;
         dma_operation_enable_out <= 1'b0;
         ctr0_tick_out <= 1'b0;
         ctr1_tick_out <= 1'b0;
         adc_trigger_out <= 1'b0;
         adc_sw_start_out <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         host_irq_out <= irq_any; // [RULE_07]
         dma_operation_enable_out <= dma_operation_enable; // [RULE_21]
         ctr0_tick_out <= ctr0_rate;
         ctr1_tick_out <= ctr1_pick;
         adc_trigger_out <= nxt_trigger;
         adc_sw_start_out <= nxt_sw_start;
      end
   end

   assign reg_rdata_out = rdata_ff;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   sequence s_basic_wr_zero;
      wr_thr && !enhanced_fifo_mode_in && (reg_req_in.wdata[BASIC_W-1:0] == 6'h00);
   endsequence

   sequence s_basic_wr_high;
      wr_thr && !enhanced_fifo_mode_in && (reg_req_in.wdata[BASIC_W-1:0] > 6'h30);
   endsequence

   sequence s_enh_rd_low;
      reg_req_in.rd && (reg_req_in.addr == 4'h5) && enhanced_fifo_mode_in;
   endsequence

   property p_basic_zero;
      s_basic_wr_zero |=> (basic_thr_ff == 6'h01);
   endproperty
   a_basic_zero: assert property (p_basic_zero) else $error("zero threshold not raised to 1"); // [RULE_10]

   property p_basic_high;
      s_basic_wr_high |=> (basic_thr_ff == 6'h30);
   endproperty
   a_basic_high: assert property (p_basic_high) else $error("high threshold not cut to 48"); // [RULE_10]

   property p_enh_first;
      enhanced_fifo_mode_in && !enh_mode_ff && !enh_seen_ff && !wr_thr
         |=> (enh_thr_ff == 12'h400);
   endproperty
   a_enh_first: assert property (p_enh_first) else $error("first enhanced entry not 1024"); // [RULE_14]

   property p_enh_rd_low;
      s_enh_rd_low |=> (reg_rdata_out == $past(fifo_count_in[7:0]));
   endproperty
   a_enh_rd_low: assert property (p_enh_rd_low) else $error("offset 5 read not count low"); // [RULE_15]

   property p_enh_rd_high;
      reg_req_in.rd && (reg_req_in.addr == 4'h6) && enhanced_fifo_mode_in
         |=> (reg_rdata_out == {4'h0, $past(fifo_count_in[11:8])});
   endproperty
   a_enh_rd_high: assert property (p_enh_rd_high) else $error("offset 6 read not count high"); // [RULE_19]

   property p_analog_set;
      analog_irq_enable && reached && !reached_ff ##1 analog_irq_enable
         |-> analog_irq_pending_ff ##1 host_irq_out;
   endproperty
   a_analog_set: assert property (p_analog_set) else $error("threshold did not raise request"); // [RULE_11]

   property p_dio_mask;
      !dio_irq_enable && !dio_irq_pending_ff |=> !dio_irq_pending_ff;
   endproperty
   a_dio_mask: assert property (p_dio_mask) else $error("masked dio request became pending"); // [RULE_04]

   property p_analog_mask;
      $rose(analog_irq_pending_ff) |-> $past(analog_irq_enable);
   endproperty
   a_analog_mask: assert property (p_analog_mask) else $error("masked analog request pending"); // [RULE_05]

   property p_no_sw_start;
      wr_cmd && analog_irq_enable |=> !adc_sw_start_out;
   endproperty
   a_no_sw_start: assert property (p_no_sw_start) else $error("software start while enabled"); // [RULE_20]

   property p_stat_read;
      reg_req_in.rd && (reg_req_in.addr == 4'h7)
         |=> (reg_rdata_out[STAT_TIMER:STAT_ANALOG] == $past({timer_irq_pending_ff, dio_irq_pending_ff,
            analog_irq_pending_ff}));
   endproperty
   a_stat_read: assert property (p_stat_read) else $error("status flags misplaced"); // [RULE_18]

   property p_shared_line;
      timer_irq_pending_ff && timer_irq_enable |=> host_irq_out;
   endproperty
   a_shared_line: assert property (p_shared_line) else $error("timer request not on shared line"); // [RULE_07]

endmodule // daqic_ctl

// ### core/daqic_pkg.sv
package daqic_pkg;

   // ---------------------------------------------------------------
   // Clock and tick rates
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int F_10M_HZ = 10_000_000;
   localparam int F_1M_HZ = 1_000_000;
   localparam int F_100K_HZ = 100_000;
   localparam int DIV_10M = CLK_HZ / F_10M_HZ;
   localparam int DIV_1M = CLK_HZ / F_1M_HZ;
   localparam int DIV_100K = CLK_HZ / F_100K_HZ;
   localparam int DIV_W = 10;
   localparam int N_TICKS = 3;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [3:0] OFS_CMD = 4'h0;
   localparam logic [3:0] OFS_CTL = 4'h4;
   localparam logic [3:0] OFS_THR = 4'h5;
   localparam logic [3:0] OFS_FDH = 4'h6;
   localparam logic [3:0] OFS_STAT = 4'h7;

   // Interrupt / counter control fields.
   localparam int CTL_CK1_SRC = 7;
   localparam int CTL_FRQ1 = 6;
   localparam int CTL_FRQ0 = 5;
   localparam int CTL_TRIG_SEL = 4;
   localparam int CTL_DMA_EN = 3;
   localparam int CTL_TIMER_EN = 2;
   localparam int CTL_DIO_EN = 1;
   localparam int CTL_ANALOG_EN = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;

   // Command register fields at offset 0.
   localparam int CMD_CLR_TIMER = 6;
   localparam int CMD_CLR_DIO = 5;
   localparam int CMD_CLR_ANALOG = 4;
   localparam int CMD_SW_START = 0;

   // Status register field positions at offset 7.
   localparam int STAT_TIMER = 6;
   localparam int STAT_DIO = 5;
   localparam int STAT_ANALOG = 4;

   // Threshold formats.
   localparam int CNT_W = 12;
   localparam int BASIC_W = 6;
   localparam logic [5:0] BASIC_MIN = 6'h01;
   localparam logic [5:0] BASIC_MAX = 6'h30;
   localparam logic [5:0] BASIC_RESET = 6'h01;
   localparam logic [11:0] ENH_AUTO = 12'h400;
   localparam logic [11:0] ENH_MAX = 12'h800;
   localparam logic [11:0] ENH_RESET = 12'h400;
   localparam logic [2:0] ENH_LOW_ZERO = 3'h0;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } daqic_reg_req_t;

   typedef struct packed {
      logic t10m;
      logic t1m;
      logic t100k;
   } daqic_tick_t;

endpackage

// ### core/daqic_tick_div.sv
`timescale 1ns/100ps

module daqic_tick_div
   import daqic_pkg::*;
(
   input wire logic mclk_in,
   input wire logic reset_in,
   output daqic_tick_t tick_out
);

   // ---------------------------------------------------------------
   // One divider per rate, each giving a one-cycle enable.
   // ---------------------------------------------------------------
   localparam logic [N_TICKS*DIV_W-1:0] TERM = {
      DIV_W'(DIV_10M - 1), DIV_W'(DIV_1M - 1), DIV_W'(DIV_100K - 1)};

   logic [N_TICKS-1:0] pulse_ff;

   genvar gi;
   generate
      for (gi = 0; gi < N_TICKS; gi++) begin : g_div
         logic [DIV_W-1:0] cnt_ff;
         wire logic at_term = (cnt_ff == TERM[gi*DIV_W +: DIV_W]);
         always_ff @(posedge mclk_in) begin
            if (reset_in) begin
               cnt_ff <= '0;
               pulse_ff[gi] <= 1'b0;
            end else begin
               cnt_ff <= at_term ? '0 : cnt_ff + DIV_W'(1);
               pulse_ff[gi] <= at_term;
            end
         end
      end
   endgenerate

   assign tick_out = '{t10m: pulse_ff[2], t1m: pulse_ff[1], t100k: pulse_ff[0]};

endmodule // daqic_tick_div

// ### tb/daqic_host_model.sv
`timescale 1ns/100ps

module daqic_host_model
   import daqic_pkg::*;
(
   input wire logic mclk_in,
   output daqic_reg_req_t reg_req_out,
   input wire logic [7:0] reg_rdata_in
);
   // ---------------------------------------------------------------
   // Host bus cycles
   // ---------------------------------------------------------------
   // Released address and data lines show the inverse of the last value.
   initial begin
      reg_req_out = '0;
   end

   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      reg_req_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_in);
      reg_req_out <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask

   task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk_in);
      reg_req_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_in);
      reg_req_out <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
      @(posedge mclk_in);
      d = reg_rdata_in;
   endtask

   // The service routine reads the pending flags and clears those it found.
   task automatic isr_clear(output logic [7:0] st);
      bus_rd(OFS_STAT, st);
      bus_wr(OFS_CMD, {1'b0, st[STAT_TIMER:STAT_ANALOG], 4'h0});
   endtask
endmodule // daqic_host_model

// ### tb/tb_daq_irq_fifo_threshold_ctl.sv
`timescale 1ns/100ps

module tb_daq_irq_fifo_threshold_ctl
   import daqic_pkg::*;
;
   // ---------------------------------------------------------------
   // Stimulus and instances
   // ---------------------------------------------------------------
   logic mclk_in = 1'b0;
   logic reset_in = 1'b1;
   daqic_reg_req_t reg_req;
   logic [7:0] rdata;
   logic [11:0] fifo_count = 12'h000;
   logic mode = 1'b0;
   logic [4:0] ev = 5'h00;
   logic irq, dma, t0, t1, trig, swst;
   wire logic [3:0] obs = {swst, trig, t1, t0};
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;

   always #5 mclk_in = ~mclk_in;

   daqic_host_model i_host (.mclk_in(mclk_in), .reg_req_out(reg_req), .reg_rdata_in(rdata));

   daqic_ctl i_dut (.mclk_in(mclk_in), .reset_in(reset_in), .reg_req_in(reg_req),
      .reg_rdata_out(rdata), .fifo_count_in(fifo_count), .enhanced_fifo_mode_in(mode),
      .timer_event_in(ev[0]), .dio_event_in(ev[1]), .ctr0_output_in(ev[2]),
      .adc_channel_in(4'h9), .ctr1_external_clock_in(ev[4]),
      .external_adc_trigger_in(ev[3]), .host_irq_out(irq), .dma_operation_enable_out(dma),
      .ctr0_tick_out(t0), .ctr1_tick_out(t1), .adc_trigger_out(trig), .adc_sw_start_out(swst));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         $display("ERROR timeout expected finish seen hang");
         tally_and_finish();
      end
   end

   task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_host.bus_rd(a, d);
      chk(nm, {4'h0, exp}, {4'h0, d});
   endtask

   task automatic pulse(input logic [4:0] m);
      @(posedge mclk_in);
      ev <= m;
      @(posedge mclk_in);
      ev <= 5'h00;
   endtask

   task automatic set_cnt(input logic [11:0] c);
      @(posedge mclk_in);
      fifo_count <= c;
   endtask

   task automatic wait_obs(input int i, input int lim, output int n);
      n = 0;
      do begin
         @(posedge mclk_in);
         n++;
      end while (obs[i] !== 1'b1 && n < lim);
   endtask

   task automatic gap_chk(input string nm, input int i, input int exp);
      int n;
      // Two edges pass first, so a tick still launched at the old rate is not the start mark.
      repeat (2) @(posedge mclk_in);
      wait_obs(i, 3000, n);
      wait_obs(i, 3000, n);
      chk(nm, exp[11:0], n[11:0]);
   endtask

   task automatic seen_chk(input string nm, input int i, input logic exp);
      int n;
      wait_obs(i, 8, n);
      chk(nm, {11'h0, exp}, {11'h0, obs[i]});
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rd_chk("control", OFS_CTL, 8'h00);
      rd_chk("threshold", OFS_THR, 8'h01);
      rd_chk("status", OFS_STAT, 8'h09);
      rd_chk("unmapped", 4'h3, 8'h00);
      chk("irq", 12'h0, {11'h0, irq});
      $display("test reset done");
   endtask

   task automatic t_ctl();
      i_host.bus_wr(OFS_CTL, 8'h08);
      @(posedge mclk_in);
      #1;
      chk("dma enable", 12'h1, {11'h0, dma});
      rd_chk("control", OFS_CTL, 8'h08);
      i_host.bus_wr(OFS_CTL, 8'h00);
      i_host.bus_wr(OFS_STAT, 8'hff);
      rd_chk("status read only", OFS_STAT, 8'h09);
      $display("test control done");
   endtask

   task automatic t_basic();
      logic [7:0] wv [5] = '{8'h00, 8'h30, 8'h31, 8'h3f, 8'h05};
      logic [7:0] xv [5] = '{8'h01, 8'h30, 8'h30, 8'h30, 8'h05};
      foreach (wv[k]) begin
         i_host.bus_wr(OFS_THR, wv[k]);
         rd_chk("basic threshold", OFS_THR, xv[k]);
      end
      $display("test basic threshold done");
   endtask

   task automatic t_irq();
      logic [7:0] st;
      i_host.bus_wr(OFS_CTL, 8'h04);
      pulse(5'h02);
      rd_chk("masked dio", OFS_STAT, 8'h09);
      i_host.bus_wr(OFS_CTL, 8'h06);
      pulse(5'h03);
      @(posedge mclk_in);
      #1;
      chk("shared irq", 12'h1, {11'h0, irq});
      rd_chk("both pending", OFS_STAT, 8'h69);
      i_host.isr_clear(st);
      rd_chk("cleared", OFS_STAT, 8'h09);
      chk("irq low", 12'h0, {11'h0, irq});
      $display("test interrupts done");
   endtask

   task automatic t_analog();
      logic [7:0] st;
      i_host.bus_wr(OFS_THR, 8'h04);
      i_host.bus_wr(OFS_CTL, 8'h01);
      set_cnt(12'h003);
      rd_chk("below threshold", OFS_STAT, 8'h09);
      set_cnt(12'h004);
      rd_chk("at threshold", OFS_STAT, 8'h19);
      chk("analog irq", 12'h1, {11'h0, irq});
      i_host.isr_clear(st);
      i_host.bus_wr(OFS_CTL, 8'h00);
      set_cnt(12'h000);
      set_cnt(12'h004);
      rd_chk("analog masked", OFS_STAT, 8'h09);
      $display("test analog threshold done");
   endtask

   task automatic t_enh();
      logic [7:0] st;
      set_cnt(12'h000);
      @(posedge mclk_in);
      mode <= 1'b1;
      set_cnt(12'h3a7);
      rd_chk("count low", OFS_THR, 8'ha7);
      rd_chk("count high", OFS_FDH, 8'h03);
      i_host.bus_wr(OFS_CTL, 8'h01);
      set_cnt(12'h3ff);
      rd_chk("below 1024", OFS_STAT, 8'h09);
      set_cnt(12'h400);
      rd_chk("at 1024", OFS_STAT, 8'h19);
      i_host.isr_clear(st);
      i_host.bus_wr(OFS_THR, 8'h01);
      set_cnt(12'h007);
      rd_chk("below 8", OFS_STAT, 8'h09);
      set_cnt(12'h008);
      rd_chk("at 8", OFS_STAT, 8'h19);
      i_host.isr_clear(st);
      @(posedge mclk_in);
      mode <= 1'b0;
      rd_chk("basic kept", OFS_THR, 8'h04);
      $display("test enhanced done");
   endtask

   task automatic t_ticks();
      i_host.bus_wr(OFS_CTL, 8'h00);
      gap_chk("ctr0 10 MHz", 0, 10);
      gap_chk("ctr1 10 MHz", 1, 10);
      i_host.bus_wr(OFS_CTL, 8'h60);
      gap_chk("ctr0 1 MHz", 0, 100);
      gap_chk("ctr1 100 kHz", 1, 1000);
      i_host.bus_wr(OFS_CTL, 8'h80);
      pulse(5'h10);
      seen_chk("ctr1 external", 1, 1'b1);
      $display("test clocks done");
   endtask

   task automatic t_trig();
      i_host.bus_wr(OFS_CTL, 8'h01);
      pulse(5'h04);
      seen_chk("ctr0 trigger", 2, 1'b1);
      i_host.bus_wr(OFS_CTL, 8'h11);
      pulse(5'h08);
      seen_chk("external trigger", 2, 1'b1);
      pulse(5'h04);
      seen_chk("ctr0 ignored", 2, 1'b0);
      i_host.bus_wr(OFS_CMD, 8'h01);
      seen_chk("start blocked", 3, 1'b0);
      i_host.bus_wr(OFS_CTL, 8'h00);
      i_host.bus_wr(OFS_CMD, 8'h01);
      seen_chk("software start", 3, 1'b1);
      $display("test triggers done");
   endtask

   initial begin
      repeat (16) @(posedge mclk_in);
      reset_in <= 1'b0;
      t_reset();
      t_ctl();
      t_basic();
      t_irq();
      t_analog();
      t_enh();
      t_ticks();
      t_trig();
      tally_and_finish();
   end
endmodule // tb_daq_irq_fifo_threshold_ctl
